// File: logic/ifeb_top.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ifeb_defines.svh"
// -----------------------------------------------------------------
// Overview of operation
// -----------------------------------------------------------------
module ifeb_top
  import ifeb_pkg::*;
#(
  parameter int LARGE_VARIANT = 1
)
(
  // clock, reset and freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hclk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // peripheral events and cpu handshake
  input  wire ifeb_evt_t   src_evt,
  input  wire logic        svc_enter,
  // requests to the cpu core
  output logic             vec_req,
  output logic             wake_req,
  output logic             irq
);

  // -----------------------------------------------------------------
  // elaboration check
  // -----------------------------------------------------------------
  if (LARGE_VARIANT != 0 && LARGE_VARIANT != 1)
  begin : g_bad
    $error("LARGE_VARIANT must be 0 or 1");
  end

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  logic [`IFEB_NSRC-1:0] flag_reg;
  logic [`IFEB_NSRC-1:0] flag_next;
  logic [`IFEB_NSRC-1:0] en_reg;
  logic [`IFEB_NSRC-1:0] en_next;
  logic [`IFEB_NSRC-1:0] evt_vec;
  logic [`IFEB_NSRC-1:0] impl;
  logic                  gie_reg;
  logic [`IFEB_NST-1:0]  stat_reg;
  logic [`IFEB_NST-1:0]  stat_next;
  logic [`IFEB_NST-1:0]  mask_reg;
  logic [`IFEB_NST-1:0]  stat_evt;
  logic                  wr_pend_reg;
  logic                  rd_pend_reg;
  logic [7:0]            addr_reg;
  logic                  hready_reg;
  logic [31:0]           hrdata_reg;
  logic                  vec_req_reg;
  logic                  wake_reg;
  logic                  irq_reg;
  logic                  accept;
  logic                  wr_gctrl;
  logic                  wr_stat;
  logic                  wr_mask;
  logic [7:0]            ctrl3_view;
  logic [7:0]            tmr0_view;
  logic [7:0]            tmr1_view;
  logic [31:0]           rd_mux;
  logic                  vec_cond;
  logic                  wake_cond;

  assign evt_vec = src_evt;

  // -----------------------------------------------------------------
  // ahb-lite front end
  // -----------------------------------------------------------------
  // a transfer is taken only in an active address phase
  assign accept = hclk_en && hsel && hready && htrans[1];

  // capture the address phase; reads get one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (hclk_en)
    begin
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      if (accept)
      begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  // the wait state lets a write just ahead land before the read samples
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hready_reg <= 1'b1;
    end
    else if (hclk_en)
    begin
      hready_reg <= !(accept && !hwrite);
    end
  end

  // read data is registered in the wait-state cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= `IFEB_DATA_RST;
    end
    else if (hclk_en && rd_pend_reg)
    begin
      hrdata_reg <= rd_mux;
    end
  end

  // -----------------------------------------------------------------
  // register views and read mux
  // -----------------------------------------------------------------
  // impl already forces absent bits low
  assign ctrl3_view = {flag_reg[3:0], en_reg[3:0]};
  assign tmr0_view = {2'b00, flag_reg[5:4], 2'b00, en_reg[5:4]};
  assign tmr1_view = {2'b00, flag_reg[7:6], 2'b00, en_reg[7:6]};

  // unmapped offsets read as zero
  always_comb
  begin
    rd_mux = `IFEB_DATA_RST;
    unique case (addr_reg)
      `IFEB_OFS_CTRL3: rd_mux[7:0] = ctrl3_view;
      `IFEB_OFS_TMR0:  rd_mux[7:0] = tmr0_view;
      `IFEB_OFS_TMR1:  rd_mux[7:0] = tmr1_view;
      `IFEB_OFS_GCTRL: rd_mux[`IFEB_GCTRL_GIE] = gie_reg;
      `IFEB_OFS_STAT:  rd_mux[`IFEB_NST-1:0] = stat_reg;
      `IFEB_OFS_MASK:  rd_mux[`IFEB_NST-1:0] = mask_reg;
      default:         rd_mux = `IFEB_DATA_RST;
    endcase
  end

  // -----------------------------------------------------------------
  // per-source flag and enable bits
  // -----------------------------------------------------------------
  for (genvar i = 0; i < `IFEB_NSRC; i++)
  begin : g_src
    localparam logic [7:0] OFS = (i < 4) ? `IFEB_OFS_CTRL3 :
                                 (i < 6) ? `IFEB_OFS_TMR0 : `IFEB_OFS_TMR1;
    localparam int FPOS = (i < 4) ? `IFEB_CTRL3_FLAG_LSB + i
                                  : `IFEB_MFI_FLAG_LSB + (i % 2);
    localparam int EPOS = (i < 4) ? i : (i % 2);
    logic wr_hit;

    // the uart source exists only in the large variant
    assign impl[i] = (i == `IFEB_UART_SRC) ? (LARGE_VARIANT == 1) : 1'b1;

    assign wr_hit = wr_pend_reg && (addr_reg == OFS);

    // event set beats a software clear in the same cycle
    assign flag_next[i] = impl[i] &&
      ((wr_hit ? hwdata[FPOS] : flag_reg[i]) || evt_vec[i]);

    // enables change only by software
    assign en_next[i] = impl[i] && (wr_hit ? hwdata[EPOS] : en_reg[i]);

    // flags latch even while the global enable is off
    AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      hclk_en && evt_vec[i] && impl[i] |=> flag_reg[i])
      else $error("event did not set its flag");
  end

  // flag bank
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_reg <= `IFEB_SRC_RST;
    end
    else if (hclk_en)
    begin
      flag_reg <= flag_next;
    end
  end

  // enable bank
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_reg <= `IFEB_SRC_RST;
    end
    else if (hclk_en)
    begin
      en_reg <= en_next;
    end
  end

  // -----------------------------------------------------------------
  // global enable and vector request
  // -----------------------------------------------------------------
  assign wr_gctrl = wr_pend_reg && (addr_reg == `IFEB_OFS_GCTRL);

  // service entry wins over a software write so nesting stays blocked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gie_reg <= 1'b0;
    end
    else if (hclk_en)
    begin
      if (svc_enter)
      begin
        gie_reg <= 1'b0;
      end
      else if (wr_gctrl)
      begin
        gie_reg <= hwdata[`IFEB_GCTRL_GIE];
      end
    end
  end

  assign vec_cond = gie_reg && |(flag_reg & en_reg);
  assign wake_cond = |flag_reg;

  // request lines to the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vec_req_reg <= 1'b0;
      wake_reg    <= 1'b0;
    end
    else if (hclk_en)
    begin
      vec_req_reg <= vec_cond;
      wake_reg    <= wake_cond;
    end
  end

  // -----------------------------------------------------------------
  // status, mask and interrupt line
  // -----------------------------------------------------------------
  // rising requests are the block's own events
  assign stat_evt[`IFEB_ST_VEC]  = vec_cond && !vec_req_reg;
  assign stat_evt[`IFEB_ST_WAKE] = wake_cond && !wake_reg;
  assign wr_stat = wr_pend_reg && (addr_reg == `IFEB_OFS_STAT);
  assign wr_mask = wr_pend_reg && (addr_reg == `IFEB_OFS_MASK);

  // write one to clear; a new event wins
  assign stat_next = (stat_reg & ~(wr_stat ? hwdata[`IFEB_NST-1:0] : `IFEB_ST_RST))
                     | stat_evt;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_reg <= `IFEB_ST_RST;
    end
    else if (hclk_en)
    begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_reg <= `IFEB_ST_RST;
    end
    else if (hclk_en && wr_mask)
    begin
      mask_reg <= hwdata[`IFEB_NST-1:0];
    end
  end

  // level output, updated on the same edge as the status
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_reg <= 1'b0;
    end
    else if (hclk_en)
    begin
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign hreadyout = hready_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = 1'b0;
  assign vec_req   = vec_req_reg;
  assign wake_req  = wake_reg;
  assign irq       = irq_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  AST_RESET_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (flag_reg == 8'h00) && (en_reg == 8'h00))
    else $error("flags or enables not zero after reset");

  AST_CTRL3_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && rd_pend_reg && addr_reg == `IFEB_OFS_CTRL3
    |=> hrdata_reg == {24'h000000, $past(ctrl3_view)})
    else $error("third control register read wrong");

  AST_TMR0_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && rd_pend_reg && addr_reg == `IFEB_OFS_TMR0
    |=> hrdata_reg[7:6] == 2'b00 && hrdata_reg[3:2] == 2'b00
        && hrdata_reg[5:4] == $past(flag_reg[5:4]))
    else $error("first mfi read wrong");

  AST_TMR1_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && rd_pend_reg && addr_reg == `IFEB_OFS_TMR1
    |=> hrdata_reg[1:0] == $past(en_reg[7:6]) && hrdata_reg[7:6] == 2'b00)
    else $error("second mfi read wrong");

  AST_SMALL_NO_UART: assert property (@(posedge hclk) disable iff (!hresetn)
    LARGE_VARIANT == 0 |-> !flag_reg[3] && !en_reg[3])
    else $error("uart bits alive in small variant");

  AST_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && wr_pend_reg && addr_reg == `IFEB_OFS_CTRL3
    |=> en_reg[2:0] == $past(hwdata[2:0]))
    else $error("enable write not stored");

  AST_SVC_CLEARS_GIE: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && svc_enter |=> !gie_reg ##1 !vec_req_reg)
    else $error("service entry left global enable set");

  AST_VEC_GATED: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en |=> vec_req_reg == ($past(gie_reg) && |($past(flag_reg) & $past(en_reg))))
    else $error("vector request wrong");

  AST_WAKE_ANY: assert property (@(posedge hclk) disable iff (!hresetn)
    hclk_en && flag_reg != 8'h00 |=> wake_reg)
    else $error("set flag did not wake");

  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout || !$past(hclk_en))
    else $error("read wait state wrong");

endmodule

// File: logic/ifeb_defines.svh
`ifndef IFEB_DEFINES_SVH
`define IFEB_DEFINES_SVH

// register byte offsets
`define IFEB_OFS_CTRL3   8'h00
`define IFEB_OFS_TMR0    8'h04
`define IFEB_OFS_TMR1    8'h08
`define IFEB_OFS_GCTRL   8'h0C
`define IFEB_OFS_STAT    8'h10
`define IFEB_OFS_MASK    8'h14

// field positions
`define IFEB_CTRL3_FLAG_LSB 4
`define IFEB_MFI_FLAG_LSB   4
`define IFEB_GCTRL_GIE      0
`define IFEB_ST_VEC         0
`define IFEB_ST_WAKE        1

// counts and reset values
`define IFEB_NSRC        8
`define IFEB_NST         2
`define IFEB_UART_SRC    3
`define IFEB_SRC_RST     8'h00
`define IFEB_ST_RST      2'h0
`define IFEB_DATA_RST    32'h0000_0000

`endif

// File: logic/ifeb_pkg.sv
package ifeb_pkg;

  // one pulse per source event, listed from bit 7 down to bit 0
  typedef struct packed {
    logic timer_one_cmp_a;
    logic timer_one_cmp_p;
    logic timer_zero_cmp_a;
    logic timer_zero_cmp_p;
    logic uart;
    logic serial_interface_module;
    logic ext_pin_one;
    logic time_base_second;
  } ifeb_evt_t;

  // sticky status events
  typedef struct packed {
    logic wake;
    logic vec;
  } ifeb_stat_t;

endpackage

// File: test/ifeb_src_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// peripheral event sources and cpu core stand-in
// ---------------------------------------------------------------
module ifeb_src_model
  import ifeb_pkg::*;
(
  // clock
  input  wire logic hclk,
  // towards the bank
  output ifeb_evt_t  src_evt,
  output logic       svc_enter
);
  // quiet until a pulse is commanded
  initial
  begin
    src_evt   = '0;
    svc_enter = 1'b0;
  end

  // one-cycle burst; events are pulses, so a level held longer would hide a lost event
  task automatic pulse(input ifeb_evt_t e, input logic s);
    @(posedge hclk);
    src_evt   <= e;
    svc_enter <= s;
    @(posedge hclk);
    src_evt   <= '0;
    svc_enter <= 1'b0;
  endtask
endmodule

// File: test/irq_flag_enable_bank_c_bench.sv
`timescale 1ns/1ps
`include "ifeb_defines.svh"
module irq_flag_enable_bank_c_bench
  import ifeb_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and register table
  // ---------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hwrite;
  logic        rd_phase;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        vec_req;
  logic        wake_req;
  logic        irq;
  ifeb_evt_t   src_evt;
  logic        svc_enter;
  int          n_mismatch;
  int          n_checks;
  logic [31:0] exp_q[$];
  logic [31:0] exp_s_q[$];
  logic [31:0] hrdata_s;
  logic        run;
  // index 4 is the w1c status, index 6 is unmapped
  localparam logic [7:0] OFS [7] = '{`IFEB_OFS_CTRL3, `IFEB_OFS_TMR0, `IFEB_OFS_TMR1,
    `IFEB_OFS_GCTRL, `IFEB_OFS_STAT, `IFEB_OFS_MASK, 8'h18};
  localparam logic [7:0] MSK [7] = '{8'hFF, 8'h33, 8'h33, 8'h01, 8'h00, 8'h03, 8'h00};

  // clock at 25 MHz
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  ifeb_top #(.LARGE_VARIANT(1)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hclk_en(run), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_evt(src_evt),
    .svc_enter(svc_enter), .vec_req(vec_req), .wake_req(wake_req), .irq(irq));

  // small variant on the same bus and events, checked through its read data
  ifeb_top #(.LARGE_VARIANT(0)) DUT_SMALL (
    .hclk(hclk), .hresetn(hresetn), .hclk_en(run), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hrdata(hrdata_s), .hresp(), .src_evt(src_evt),
    .svc_enter(svc_enter), .vec_req(), .wake_req(), .irq());

  ifeb_src_model model (.hclk(hclk), .src_evt(src_evt), .svc_enter(svc_enter));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single ahb transfer; read expectations go to the monitor's queue
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans   <= 2'h0;
    hwdata   <= wr ? d : 32'h0;
    rd_phase <= !wr;
    if (!wr) exp_q.push_back(d);
    if (!wr) exp_s_q.push_back(a == `IFEB_OFS_CTRL3 ? d & ~32'h88 : d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, e);
  endtask

  // look at {vec_req, wake_req, irq} mid-cycle, then realign to a rising edge
  task automatic pins(input int n, input logic [2:0] e);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
    cmp({29'h0, vec_req, wake_req, irq}, {29'h0, e});
    @(posedge hclk);
  endtask

  task automatic done(input string s);
    $display("test %0s finished", s);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // read data is taken at the edge that ends the data phase
  always @(posedge hclk)
  begin
    if (rd_phase && hreadyout === 1'b1)
    begin
      cmp(hrdata, exp_q.pop_front());
      cmp(hrdata_s, exp_s_q.pop_front());
      cmp({31'h0, hresp}, 32'h0);
    end
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    final_report;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    hresetn  = 1'b0;
    htrans   = 2'h0;
    haddr    = 32'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    rd_phase = 1'b0;
    run      = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(87));
    for (int i = 0; i < 7; i++) rd(OFS[i], 32'h0);
    done("reset");
    repeat (4) for (int i = 0; i < 7; i++) if (i != 4)
    begin
      r = $urandom;
      wr(OFS[i], r);
      rd(OFS[i], r & {24'h0, MSK[i]});
    end
    for (int i = 0; i < 7; i++) if (i != 4) wr(OFS[i], 32'h0);
    wr(`IFEB_OFS_STAT, 32'h3);
    rd(`IFEB_OFS_STAT, 32'h0);
    pins(1, 3'b000);
    done("read write");
    // every source with its enable off: flag lands in its bit, wake still raised
    for (int i = 0; i < 8; i++)
    begin
      model.pulse(ifeb_evt_t'(8'h01 << i), 1'b0);
      pins(1, 3'b010);
      r = i < 4 ? `IFEB_OFS_CTRL3 : (i < 6 ? `IFEB_OFS_TMR0 : `IFEB_OFS_TMR1);
      rd(r[7:0], 32'h1 << (i < 4 ? 4 + i : 4 + i % 2));
      wr(r[7:0], 32'h0);
    end
    done("events");
    // vector only with source and global enable; service entry drops global enable
    wr(`IFEB_OFS_STAT, 32'h3);
    wr(`IFEB_OFS_CTRL3, 32'h04);
    wr(`IFEB_OFS_MASK, 32'h3);
    model.pulse(ifeb_evt_t'(8'h04), 1'b0);
    pins(2, 3'b011);
    wr(`IFEB_OFS_GCTRL, 32'h1);
    pins(1, 3'b111);
    rd(`IFEB_OFS_STAT, 32'h3);
    model.pulse(ifeb_evt_t'(8'h02), 1'b1);
    pins(1, 3'b011);
    rd(`IFEB_OFS_GCTRL, 32'h0);
    rd(`IFEB_OFS_CTRL3, 32'h64);
    wr(`IFEB_OFS_STAT, 32'h3);
    pins(1, 3'b010);
    rd(`IFEB_OFS_STAT, 32'h0);
    done("vector and service");
    // clock enable low: an event in that span is lost and the bank keeps its value
    run <= 1'b0;
    model.pulse(ifeb_evt_t'(8'h01), 1'b0);
    run <= 1'b1;
    rd(`IFEB_OFS_CTRL3, 32'h64);
    done("clock enable freeze");
    final_report;
  end
endmodule
